// ===== prescale_if.sv
// Carrier between the timer core and its prescaler
`timescale 1ns/10ps
`default_nettype none
interface prescale_if;
  logic       tick_in;
  logic [1:0] div_sel;
  logic       tick_out;
  modport core (output tick_in, output div_sel, input tick_out);
  modport pre  (input tick_in, input div_sel, output tick_out);
endinterface : prescale_if
`default_nettype wire

// ===== sixteen_bit_timer.sv
// Sixteen-bit up-counting interval timer with selectable interrupt bit
`timescale 1ns/10ps
`default_nettype none

module sixteen_bit_timer (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // IO register port
  input  wire logic [5:0]  io_addr,
  input  wire logic [7:0]  io_wdata,
  input  wire logic        io_we,
  output var  logic [7:0]  io_rdata,
  // Counter move instructions
  input  wire logic        counter_store_instr,
  input  wire logic [15:0] store_word,
  input  wire logic        counter_load_instr,
  output var  logic [15:0] load_word,
  // Clock source pins, asynchronous
  input  wire logic        fast_internal_rc,
  input  wire logic        crystal_osc,
  input  wire logic        slow_internal_rc,
  input  wire logic        pin_a4_edge_source,
  input  wire logic        pin_a0_edge_source,
  // Interrupt request
  output var  logic        timer_request
);

  // ****************************************
  // Register state
  // ****************************************
  logic [7:0]  sixteen_bit_timer_mode_reg;
  logic [7:0]  next_mode;
  logic [7:0]  edge_sel;
  logic [7:0]  next_edge_sel;
  logic        next_request;
  logic [7:0]  next_rdata;
  logic [15:0] count;
  logic [15:0] next_count;
  logic [15:0] next_load_word;
  logic        sel_prev;
  logic        next_sel_prev;

  sixteen_bit_timer_pkg::src_t src;
  logic [1:0]        div_sel;
  logic [2:0]        bit_sel;
  logic              sel_now;
  logic              edge_evt;
  logic              src_tick;

  assign src     = sixteen_bit_timer_pkg::src_t'(
                     sixteen_bit_timer_mode_reg[sixteen_bit_timer_pkg::SRC_LSB +: 3]);
  assign div_sel = sixteen_bit_timer_mode_reg[sixteen_bit_timer_pkg::PRE_LSB +: 2];
  assign bit_sel = sixteen_bit_timer_mode_reg[sixteen_bit_timer_pkg::BITSEL_LSB +: 3];

  // ****************************************
  // Pin synchronisers and edge detect
  // ****************************************
  // Each slow source is treated as a clock sampled by clk; it must stay
  // well below clk/2 or edges are lost.
  logic [sixteen_bit_timer_pkg::NUM_PINS-1:0] pins;
  logic [sixteen_bit_timer_pkg::NUM_PINS-1:0] sync1;
  logic [sixteen_bit_timer_pkg::NUM_PINS-1:0] sync2;
  logic [sixteen_bit_timer_pkg::NUM_PINS-1:0] sync3;
  logic [sixteen_bit_timer_pkg::NUM_PINS-1:0] rise;

  assign pins = {pin_a0_edge_source, slow_internal_rc, crystal_osc,
                 fast_internal_rc, pin_a4_edge_source};

  genvar gi;
  generate
    for (gi = 0; gi < sixteen_bit_timer_pkg::NUM_PINS; gi++) begin : g_sync
      always_ff @(posedge clk) begin
        if (rst) begin
          sync1[gi] <= 1'b0;
          sync2[gi] <= 1'b0;
          sync3[gi] <= 1'b0;
        end else begin
          sync1[gi] <= pins[gi];
          sync2[gi] <= sync1[gi];
          sync3[gi] <= sync2[gi];
        end
      end
      assign rise[gi] = sync2[gi] && !sync3[gi];
    end
  endgenerate

  always_comb begin
    case (src)
      sixteen_bit_timer_pkg::SRC_SYS:     src_tick = 1'b1;
      sixteen_bit_timer_pkg::SRC_PA4:     src_tick = rise[0];
      sixteen_bit_timer_pkg::SRC_FAST_RC: src_tick = rise[1];
      sixteen_bit_timer_pkg::SRC_XTAL:    src_tick = rise[2];
      sixteen_bit_timer_pkg::SRC_SLOW_RC: src_tick = rise[3];
      sixteen_bit_timer_pkg::SRC_PA0:     src_tick = rise[4];
      default:                  src_tick = 1'b0;
    endcase
  end

  // ****************************************
  // Prescaler
  // ****************************************
  prescale_if pif ();
  assign pif.tick_in = src_tick;
  assign pif.div_sel = div_sel;

  sixteen_bit_timer_prescaler u_pre (
    .clk (clk),
    .rst (rst),
    .pif (pif)
  );

  // ****************************************
  // Counter and interrupt source
  // ****************************************
  assign sel_now  = count[sixteen_bit_timer_pkg::BITSEL_BASE + int'(bit_sel)];
  // Edge bit low selects rising, high selects falling
  assign edge_evt = edge_sel[sixteen_bit_timer_pkg::EDGE_BIT] ?
                    (sel_prev && !sel_now) : (!sel_prev && sel_now);

  always_comb begin
    next_count     = count;
    next_load_word = load_word;
    next_sel_prev  = sel_now;
    // Store overrides a simultaneous tick so software sees its own value
    if (counter_store_instr) begin
      next_count = store_word;
    end else if (pif.tick_out) begin
      next_count = count + 16'h0001;
    end
    if (counter_load_instr) begin
      next_load_word = count;
    end
  end

  // ****************************************
  // IO registers
  // ****************************************
  always_comb begin
    next_mode     = sixteen_bit_timer_mode_reg;
    next_edge_sel = edge_sel;
    next_request  = timer_request;
    if (io_we) begin
      case (io_addr)
        sixteen_bit_timer_pkg::MODE_ADDR:  next_mode = io_wdata;
        sixteen_bit_timer_pkg::EDGE_ADDR:  next_edge_sel = io_wdata;
        sixteen_bit_timer_pkg::INTRQ_ADDR:
          next_request = io_wdata[sixteen_bit_timer_pkg::INTRQ_BIT];
        default: next_mode = sixteen_bit_timer_mode_reg;
      endcase
    end
    // A set in the same cycle as a clear wins
    if (edge_evt) begin
      next_request = 1'b1;
    end
    case (io_addr)
      sixteen_bit_timer_pkg::MODE_ADDR:  next_rdata = next_mode;
      sixteen_bit_timer_pkg::EDGE_ADDR:  next_rdata = next_edge_sel;
      sixteen_bit_timer_pkg::INTRQ_ADDR:
        next_rdata = {5'h00, next_request, 2'h0};
      default:                 next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sixteen_bit_timer_mode_reg <= sixteen_bit_timer_pkg::MODE_RESET;
      edge_sel         <= sixteen_bit_timer_pkg::EDGE_RESET;
      timer_request    <= 1'b0;
      io_rdata         <= 8'h00;
      count            <= 16'h0000;
      load_word        <= 16'h0000;
      sel_prev         <= 1'b0;
    end else begin
      sixteen_bit_timer_mode_reg <= next_mode;
      edge_sel         <= next_edge_sel;
      timer_request    <= next_request;
      io_rdata         <= next_rdata;
      count            <= next_count;
      load_word        <= next_load_word;
      sel_prev         <= next_sel_prev;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_stop_holds: assert property (@(posedge clk) disable iff (rst)
    (src == sixteen_bit_timer_pkg::SRC_STOP && !counter_store_instr)
    |=> count == $past(count))
    else $error("counter moved while stopped");

  a_rsvd_holds: assert property (@(posedge clk) disable iff (rst)
    (src == sixteen_bit_timer_pkg::SRC_RSVD && !counter_store_instr)
    |=> count == $past(count))
    else $error("counter moved on reserved source");

  a_sys_steps: assert property (@(posedge clk) disable iff (rst)
    (src == sixteen_bit_timer_pkg::SRC_SYS && div_sel == 2'h0 &&
     !counter_store_instr) |=> count == $past(count) + 16'h0001)
    else $error("counter did not step by one");

  a_store_loads: assert property (@(posedge clk) disable iff (rst)
    counter_store_instr |=> count == $past(store_word))
    else $error("store did not load the counter");

  a_load_copies: assert property (@(posedge clk) disable iff (rst)
    counter_load_instr |=> load_word == $past(count))
    else $error("load did not copy the count");

  a_edge_sets: assert property (@(posedge clk) disable iff (rst)
    edge_evt |=> timer_request)
    else $error("edge did not raise the request");

  a_edge_polarity: assert property (@(posedge clk) disable iff (rst)
    edge_evt |-> sel_now == !edge_sel[sixteen_bit_timer_pkg::EDGE_BIT])
    else $error("interrupt on wrong transition");

  a_clear_works: assert property (@(posedge clk) disable iff (rst)
    (io_we && io_addr == sixteen_bit_timer_pkg::INTRQ_ADDR &&
     !io_wdata[sixteen_bit_timer_pkg::INTRQ_BIT] && !edge_evt) |=> !timer_request)
    else $error("request flag not cleared");

  a_bit8_period: assert property (@(posedge clk) disable iff (rst)
    (src == sixteen_bit_timer_pkg::SRC_SYS && div_sel == 2'h0 && bit_sel == 3'h0 &&
     edge_sel[sixteen_bit_timer_pkg::EDGE_BIT] == 1'b0 && count == 16'h00ff &&
     !counter_store_instr && !io_we) |=> ##1 timer_request)
    else $error("bit 8 rising did not request on time");

endmodule : sixteen_bit_timer
`default_nettype wire

// ===== sixteen_bit_timer_pkg.sv
// Constants and types shared by the sixteen-bit interval timer
package sixteen_bit_timer_pkg;

  // ****************************************
  // IO map
  // ****************************************
  localparam logic [5:0] MODE_ADDR  = 6'h06;
  localparam logic [5:0] EDGE_ADDR  = 6'h0c;
  localparam logic [5:0] INTRQ_ADDR = 6'h05;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int         SRC_LSB     = 5;
  localparam int         PRE_LSB     = 3;
  localparam int         BITSEL_LSB  = 0;
  localparam int         BITSEL_BASE = 8;
  localparam int         EDGE_BIT    = 4;
  localparam int         INTRQ_BIT   = 2;
  localparam logic [7:0] MODE_RESET  = 8'h00;
  localparam logic [7:0] EDGE_RESET  = 8'h00;
  localparam int         PRE_WIDTH   = 6;
  localparam int         SYNC_STAGES = 2;
  localparam int         NUM_PINS    = 5;

  // Clock source codes in field order
  typedef enum logic [2:0] {
    SRC_STOP,
    SRC_SYS,
    SRC_RSVD,
    SRC_PA4,
    SRC_FAST_RC,
    SRC_XTAL,
    SRC_SLOW_RC,
    SRC_PA0
  } src_t;

endpackage : sixteen_bit_timer_pkg

// ===== sixteen_bit_timer_prescaler.sv
// Divide-by-1/4/16/64 prescaler for the sixteen-bit timer
`timescale 1ns/10ps
`default_nettype none
module sixteen_bit_timer_prescaler (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Core side
  prescale_if.pre   pif
);

  logic [sixteen_bit_timer_pkg::PRE_WIDTH-1:0] cnt;
  logic [sixteen_bit_timer_pkg::PRE_WIDTH-1:0] next_cnt;
  logic [sixteen_bit_timer_pkg::PRE_WIDTH-1:0] mask;

  function automatic logic [sixteen_bit_timer_pkg::PRE_WIDTH-1:0] div_mask(
    input logic [1:0] sel);
    case (sel)
      2'h0:    div_mask = 6'h00;
      2'h1:    div_mask = 6'h03;
      2'h2:    div_mask = 6'h0f;
      default: div_mask = 6'h3f;
    endcase
  endfunction : div_mask

  always_comb begin
    mask     = div_mask(pif.div_sel);
    next_cnt = cnt;
    if (pif.tick_in) begin
      next_cnt = cnt + 6'h01;
    end
    pif.tick_out = pif.tick_in && ((cnt & mask) == mask);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt <= '0;
    end else begin
      cnt <= next_cnt;
    end
  end

  a_div_one_pass: assert property (@(posedge clk) disable iff (rst)
    (pif.div_sel == 2'h0 && pif.tick_in) |-> pif.tick_out)
    else $error("divide-by-1 dropped a tick");

  a_div_needs_in: assert property (@(posedge clk) disable iff (rst)
    pif.tick_out |-> pif.tick_in)
    else $error("prescaler ticked without an input tick");

endmodule : sixteen_bit_timer_prescaler
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the sixteen-bit interval timer
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // ****************************************
  // Signals and bench state
  // ****************************************
  localparam int LIMIT = 90000;
  logic        clk;
  logic        rst;
  logic [5:0]  io_addr;
  logic [7:0]  io_wdata;
  logic        io_we;
  logic [7:0]  io_rdata;
  logic        counter_store_instr;
  logic [15:0] store_word;
  logic        counter_load_instr;
  logic [15:0] load_word;
  logic [4:0]  pins;
  logic        timer_request;
  logic [15:0] x;
  int          errors;
  int          n_compared;
  int          cycles;
  int          waited;
  int          n;
  time         tp;
  int          pre[7]  = '{0, 0, 0, 0, 1, 2, 3};
  int          bsel[7] = '{0, 0, 1, 5, 0, 0, 0};
  int          fall[7] = '{0, 1, 0, 0, 0, 0, 0};
  sixteen_bit_timer_pkg::src_t srcs[3] = '{sixteen_bit_timer_pkg::SRC_STOP,
                                 sixteen_bit_timer_pkg::SRC_RSVD,
                                 sixteen_bit_timer_pkg::SRC_SYS};

  sixteen_bit_timer i_dut (
    .clk                (clk),
    .rst                (rst),
    .io_addr            (io_addr),
    .io_wdata           (io_wdata),
    .io_we              (io_we),
    .io_rdata           (io_rdata),
    .counter_store_instr(counter_store_instr),
    .store_word         (store_word),
    .counter_load_instr (counter_load_instr),
    .load_word          (load_word),
    .fast_internal_rc   (pins[1]),
    .crystal_osc        (pins[2]),
    .slow_internal_rc   (pins[3]),
    .pin_a4_edge_source (pins[0]),
    .pin_a0_edge_source (pins[4]),
    .timer_request      (timer_request)
  );

  always #2 clk = ~clk;

  // A hang anywhere ends in the same verdict path
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      errors++;
      results();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk);
    io_addr  = a;
    io_wdata = d;
    io_we    = 1'b1;
    @(negedge clk);
    io_we = 1'b0;
  endtask : wr

  // Read data is registered, so it is looked at one edge later
  task automatic rd(input logic [5:0] a);
    @(negedge clk);
    io_addr = a;
    @(negedge clk);
  endtask : rd

  task automatic st(input logic [15:0] w);
    @(negedge clk);
    store_word          = w;
    counter_store_instr = 1'b1;
    @(negedge clk);
    counter_store_instr = 1'b0;
  endtask : st

  task automatic ld();
    @(negedge clk);
    counter_load_instr = 1'b1;
    @(negedge clk);
    counter_load_instr = 1'b0;
  endtask : ld

  task automatic wait_req(input int lim);
    waited = 0;
    while (timer_request !== 1'b1 && waited < lim) begin
      @(negedge clk);
      waited++;
    end
  endtask : wait_req

  task automatic results();
    if (errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {io_addr, io_wdata, io_we, store_word} = '0;
    {counter_store_instr, counter_load_instr, pins} = '0;
    {errors, n_compared, cycles} = '0;
    void'($urandom(32'h5690));
    repeat (3) @(negedge clk);
    rst = 1'b0;
    check(load_word, 16'h0000);
    check({15'h0, timer_request}, 16'h0000);
    rd(sixteen_bit_timer_pkg::MODE_ADDR);
    check({8'h00, io_rdata}, {8'h00, sixteen_bit_timer_pkg::MODE_RESET});
    wr(sixteen_bit_timer_pkg::MODE_ADDR, 8'ha5);
    rd(sixteen_bit_timer_pkg::MODE_ADDR);
    check({8'h00, io_rdata}, 16'h00a5);
    wr(sixteen_bit_timer_pkg::EDGE_ADDR, 8'h10);
    rd(sixteen_bit_timer_pkg::EDGE_ADDR);
    check({8'h00, io_rdata}, 16'h0010);
    wr(6'h3f, 8'hff);
    rd(6'h3f);
    check({8'h00, io_rdata}, 16'h0000);
    wr(sixteen_bit_timer_pkg::INTRQ_ADDR, 8'hff);
    rd(sixteen_bit_timer_pkg::INTRQ_ADDR);
    check({8'h00, io_rdata}, 16'h0004);
    wr(sixteen_bit_timer_pkg::INTRQ_ADDR, 8'h00);
    rd(sixteen_bit_timer_pkg::INTRQ_ADDR);
    check({8'h00, io_rdata}, 16'h0000);
    // Stop and reserved hold; system clock counts through the wrap
    foreach (srcs[i]) begin
      wr(sixteen_bit_timer_pkg::MODE_ADDR, {srcs[i], 5'h00});
      x = (i == 2) ? 16'hfff0 : 16'($urandom);
      st(x);
      repeat (32) @(negedge clk);
      ld();
      check(load_word, (i == 2) ? x + 16'd33 : x);
    end
    // Unselected sources get extra edges that must not count
    for (int c = 3; c < 8; c++) begin
      n = 1 + int'($urandom % 12);
      wr(sixteen_bit_timer_pkg::MODE_ADDR, {3'(c), 5'h00});
      st(16'h0000);
      for (int i = 0; i < n + 3; i++) begin
        @(negedge clk);
        pins = (i < n) ? 5'h1f : ~(5'h01 << (c - 3));
        repeat (3) @(negedge clk);
        pins = 5'h00;
        repeat (2) @(negedge clk);
      end
      repeat (8) @(negedge clk);
      ld();
      check(load_word, 16'(n));
    end
    // Request timing: first event from zero, then free-running period
    for (int k = 0; k < 7; k++) begin
      wr(sixteen_bit_timer_pkg::EDGE_ADDR, (fall[k] != 0) ? 8'h10 : 8'h00);
      wr(sixteen_bit_timer_pkg::MODE_ADDR, {3'(sixteen_bit_timer_pkg::SRC_SYS), 2'(pre[k]),
                                  3'(bsel[k])});
      st(16'h0000);
      wr(sixteen_bit_timer_pkg::INTRQ_ADDR, 8'h00);
      wait_req(70000);
      if (pre[k] == 0)
        check(16'(waited),
              16'((1 << (8 + bsel[k] + fall[k])) - 1));
      if (bsel[k] != 5) begin
        tp = $time;
        wr(sixteen_bit_timer_pkg::INTRQ_ADDR, 8'h00);
        wait_req(70000);
        check(16'(($time - tp) / 4),
              16'((4 ** pre[k]) << (9 + bsel[k])));
      end
    end
    // Every interrupt bit from just below its edge; bit 15 falls on the wrap.
    // A one-step gap makes the set land on the clear write: set must win.
    for (int b = 0; b < 8; b++) begin
      n = (b == 3) ? 1 : 16;
      wr(sixteen_bit_timer_pkg::EDGE_ADDR, (b == 7) ? 8'h10 : 8'h00);
      wr(sixteen_bit_timer_pkg::MODE_ADDR, {3'(sixteen_bit_timer_pkg::SRC_SYS), 2'h0, 3'(b)});
      st(16'((1 << (8 + b + int'(b == 7))) - n));
      wr(sixteen_bit_timer_pkg::INTRQ_ADDR, 8'h00);
      wait_req(64);
      check(16'(waited), 16'(n - 1));
    end
    results();
  end
endmodule : tb_top
`default_nettype wire
